/* lsb_ctrl.sv */
// Functional notes
// R1 - pump clock is display clock over six times two to (adjust plus one)
// R2 - high drive select: 0 normal buffer drive, 1 high buffer drive
// R3 - buffer bypass: 0 buffered path, 1 unbuffered operation
// R4 - software leaves supply source unchanged while module enabled
// R5 - supply source 00 makes intermediate supply level internally
// R6 - blink control readable and writable any time; rate kept while blinking
// R7 - display clock from external reference on 0, bus clock on 1
// R8 - wait mode disable set turns display off in wait mode
// R9 - stop3 disable clear keeps display running in stop3
// R10 - duty field 11 selects quarter duty with four backplanes
// R11 - blink mode 0 blinks selected segments, 1 blinks all
// R12 - pump enable set turns the charge pump on
// R13 - pump multiplier 0 doubler, 1 tripler
// R14 - display clock scaled by divide-by-16 select and six-bit adjust
// R15 - one enable per frontplane, forty lines, driven only when enabled
// R16 - pump divider free-running, reloads on adjust change, no short period
`default_nettype none
module lsb_ctrl #(
  parameter int FP_COUNT = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_ref_clk,
  input wire logic wait_mode,
  input wire logic stop3_mode,
  output logic display_on,
  output logic display_tick,
  output logic pump_clk,
  output logic pump_on,
  output logic pump_tripler,
  output logic high_drive_select,
  output logic buffer_bypass,
  output logic intermediate_supply_gen,
  output logic quarter_duty,
  output logic [1:0] duty_select,
  output logic [2:0] frame_clock_select,
  output logic blank_all,
  output logic blank_selected,
  output logic [FP_COUNT-1:0] frontplane_drive
);

  // ----------------------------------------------------------------------
  // register file and bus state
  // ----------------------------------------------------------------------
  logic [7:0] clk_cfg_reg, clk_cfg_next;
  logic [7:0] sup_cfg_reg, sup_cfg_next;
  logic [7:0] cr0_reg, cr0_next;
  logic [7:0] cr1_reg, cr1_next;
  logic [7:0] blk_reg, blk_next;
  logic [FP_COUNT-1:0] fp_reg, fp_next;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic have_aw, have_w, do_write;
  logic [7:0] wa;
  logic [31:0] wd, fp_word_lo, fp_word_hi, status_word;
  logic [3:0] ws;

  // mapped offsets: everything below the status word, aligned; the status word on reads only
  function automatic logic addr_hit(input logic [7:0] a, input logic rd);
    logic hit;
    hit = 1'b0;
    case (a)
      lsb_pkg::OFS_CLOCK_CFG, lsb_pkg::OFS_SUPPLY_CFG,
      lsb_pkg::OFS_CONTROL_ZERO, lsb_pkg::OFS_CONTROL_ONE,
      lsb_pkg::OFS_BLINK_CTRL, lsb_pkg::OFS_FP_ENABLE_LO,
      lsb_pkg::OFS_FP_ENABLE_HI: hit = 1'b1;
      lsb_pkg::OFS_STATUS: hit = rd;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign have_aw = aw_got_reg || (s_axi_awvalid && s_axi_awready);
  assign have_w = w_got_reg || (s_axi_wvalid && s_axi_wready);
  assign do_write = have_aw && have_w && !bvalid_reg;
  assign wa = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  assign wd = w_got_reg ? wdata_reg : s_axi_wdata;
  assign ws = w_got_reg ? wstrb_reg : s_axi_wstrb;
  assign fp_word_lo = 32'(fp_reg[31:0]);
  assign fp_word_hi = 32'(fp_reg[FP_COUNT-1:32]);

  // write path: address and data taken in either order, answer follows both
  always_comb begin
    clk_cfg_next = clk_cfg_reg;
    sup_cfg_next = sup_cfg_reg;
    cr0_next = cr0_reg;
    cr1_next = cr1_reg;
    blk_next = blk_reg;
    fp_next = fp_reg;
    aw_got_next = have_aw && !do_write;
    w_got_next = have_w && !do_write;
    awaddr_next = wa;
    wdata_next = wd;
    wstrb_next = ws;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    if (do_write) begin
      bvalid_next = 1'b1;
      bresp_next = addr_hit(wa, 1'b0) ? lsb_pkg::RESP_OKAY
                                       : lsb_pkg::RESP_SLVERR;
      if (ws[0]) begin
        // blink control accepted at any time, blinking or not
        case (wa)
          lsb_pkg::OFS_CLOCK_CFG: clk_cfg_next = wd[7:0];
          lsb_pkg::OFS_SUPPLY_CFG: sup_cfg_next = wd[7:0];
          lsb_pkg::OFS_CONTROL_ZERO: cr0_next = wd[7:0];
          lsb_pkg::OFS_CONTROL_ONE: cr1_next = wd[7:0] & 8'h03;
          lsb_pkg::OFS_BLINK_CTRL: blk_next = wd[7:0] & 8'h8f; // R6
          lsb_pkg::OFS_FP_ENABLE_HI: fp_next[FP_COUNT-1:32] = wd[7:0];
          default: ;
        endcase
      end
      if (wa == lsb_pkg::OFS_FP_ENABLE_LO) begin
        for (int b = 0; b < 4; b++) begin
          if (ws[b]) begin
            fp_next[b*8 +: 8] = wd[b*8 +: 8]; // R15
          end
        end
      end
    end
  end

  // read path: answer one cycle after the address is taken
  always_comb begin
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = addr_hit(s_axi_araddr, 1'b1) ? lsb_pkg::RESP_OKAY
                                                 : lsb_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        lsb_pkg::OFS_CLOCK_CFG: rdata_next = 32'(clk_cfg_reg);
        lsb_pkg::OFS_SUPPLY_CFG: rdata_next = 32'(sup_cfg_reg);
        lsb_pkg::OFS_CONTROL_ZERO: rdata_next = 32'(cr0_reg);
        lsb_pkg::OFS_CONTROL_ONE: rdata_next = 32'(cr1_reg);
        lsb_pkg::OFS_BLINK_CTRL: rdata_next = 32'(blk_reg); // R6
        lsb_pkg::OFS_FP_ENABLE_LO: rdata_next = fp_word_lo;
        lsb_pkg::OFS_FP_ENABLE_HI: rdata_next = fp_word_hi;
        lsb_pkg::OFS_STATUS: rdata_next = status_word;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_cfg_reg <= lsb_pkg::CLOCK_CFG_RST;
      sup_cfg_reg <= lsb_pkg::SUPPLY_CFG_RST;
      cr0_reg <= lsb_pkg::CONTROL_ZERO_RST;
      cr1_reg <= lsb_pkg::CONTROL_ONE_RST;
      blk_reg <= lsb_pkg::BLINK_CTRL_RST;
      fp_reg <= '0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      clk_cfg_reg <= clk_cfg_next;
      sup_cfg_reg <= sup_cfg_next;
      cr0_reg <= cr0_next;
      cr1_reg <= cr1_next;
      blk_reg <= blk_next;
      fp_reg <= fp_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // ----------------------------------------------------------------------
  // display clock chain
  // ----------------------------------------------------------------------
  logic [2:0] ref_sync_reg;
  logic ref_lvl_reg, ref_lvl_next;
  logic [3:0] pre_reg, pre_next;
  logic [5:0] adj_cnt_reg, adj_cnt_next;
  logic tick_reg, tick_next;
  logic src_tick, pre_tick;
  logic [15:0] blink_cnt_reg, blink_cnt_next;
  logic on_reg, on_next, phase;

  // the reference pin is unrelated to aclk; a level counts once stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_sync_reg <= 3'h0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[1:0], ext_ref_clk};
    end
  end

  // source pick, then divide-by-16 prescale, then adjust+1 division
  always_comb begin
    ref_lvl_next = ref_lvl_reg;
    if (ref_sync_reg[1] == ref_sync_reg[2]) begin
      ref_lvl_next = ref_sync_reg[2];
    end
    src_tick = clk_cfg_reg[lsb_pkg::CLK_SOURCE_BIT] ? 1'b1
             : (ref_lvl_next && !ref_lvl_reg); // R7
    pre_next = pre_reg;
    pre_tick = src_tick;
    if (clk_cfg_reg[lsb_pkg::CLK_DIVIDE_BY_SIXTEEN_BIT]) begin
      pre_tick = src_tick && pre_reg == 4'(lsb_pkg::PRESCALE_SIXTEEN - 1);
      if (src_tick) begin
        pre_next = pre_reg + 4'h1; // R14
      end
    end
    adj_cnt_next = adj_cnt_reg;
    tick_next = 1'b0;
    if (pre_tick) begin
      if (adj_cnt_reg >= clk_cfg_reg[5:0]) begin
        adj_cnt_next = 6'h00; // R14
        tick_next = 1'b1;
      end else begin
        adj_cnt_next = adj_cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_lvl_reg <= 1'b0;
      pre_reg <= 4'h0;
      adj_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      ref_lvl_reg <= ref_lvl_next;
      pre_reg <= pre_next;
      adj_cnt_reg <= adj_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // ----------------------------------------------------------------------
  // low-power gating and blink timing
  // ----------------------------------------------------------------------
  // blink counter free-runs while blinking so rate steps stay aligned
  assign phase = blink_cnt_reg[4'(blk_reg[2:0]) + 4'(lsb_pkg::BLINK_SHIFT)];

  always_comb begin
    on_next = cr0_reg[lsb_pkg::CR0_MODULE_EN_BIT]
      && !(wait_mode && cr1_reg[lsb_pkg::CR1_WAIT_DIS_BIT]) // R8
      && !(stop3_mode && cr1_reg[lsb_pkg::CR1_STOP3_DIS_BIT]); // R9
    blink_cnt_next = blink_cnt_reg;
    if (!blk_reg[lsb_pkg::BLK_ENABLE_BIT]) begin
      blink_cnt_next = 16'h0000;
    end else if (tick_reg) begin
      blink_cnt_next = blink_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_reg <= 1'b0;
      blink_cnt_reg <= 16'h0000;
    end else begin
      on_reg <= on_next;
      blink_cnt_reg <= blink_cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // charge pump divider and outputs
  // ----------------------------------------------------------------------
  lsb_pump_if pif ();
  assign pif.tick = tick_reg;
  assign pif.enable = sup_cfg_reg[lsb_pkg::SUP_PUMP_EN_BIT] && on_reg; // R12
  assign pif.adjust = sup_cfg_reg[lsb_pkg::SUP_PUMP_ADJ_LSB +: 2]; // R1

  lsb_pump_div u_pump (
    .aclk(aclk),
    .aresetn(aresetn),
    .pif(pif)
  );

  // all straight from registers; gating keeps frontplanes quiet when off
  assign display_on = on_reg;
  assign display_tick = tick_reg && on_reg;
  assign pump_clk = pif.pump_clk;
  assign pump_on = pif.enable; // R12
  assign pump_tripler = sup_cfg_reg[lsb_pkg::SUP_PUMP_MULT_BIT]; // R13
  assign high_drive_select = sup_cfg_reg[lsb_pkg::SUP_HIGH_DRIVE_BIT]; // R2
  assign buffer_bypass = sup_cfg_reg[lsb_pkg::SUP_BYPASS_BIT]; // R3
  assign intermediate_supply_gen = on_reg
    && sup_cfg_reg[1:0] == lsb_pkg::SUPPLY_INTERNAL; // R5
  assign duty_select = cr0_reg[1:0];
  assign quarter_duty = cr0_reg[1:0] == lsb_pkg::DUTY_QUARTER; // R10
  assign frame_clock_select = cr0_reg[lsb_pkg::CR0_FRAME_SEL_LSB +: 3];
  assign blank_all = on_reg && blk_reg[lsb_pkg::BLK_ENABLE_BIT]
    && blk_reg[lsb_pkg::BLK_ALL_BIT] && phase; // R11
  assign blank_selected = on_reg && blk_reg[lsb_pkg::BLK_ENABLE_BIT]
    && !blk_reg[lsb_pkg::BLK_ALL_BIT] && phase; // R11
  assign frontplane_drive = on_reg ? fp_reg : '0; // R15
  assign status_word = {27'h0, pif.pump_clk, blank_all | blank_selected,
                        tick_reg, pif.enable, on_reg};

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_write_answer;
    s_axi_bvalid [*1] ##0 !s_axi_awready;
  endsequence

  a_write_answer_next: assert property (s_write_taken |=> s_write_answer)
    else $error("write answer missing after address and data");
  a_read_holds_data: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");
  a_blink_any_time: assert property ( // R6
    s_write_taken and (s_axi_wstrb[0]
    && s_axi_awaddr == lsb_pkg::OFS_BLINK_CTRL)
    |=> blk_reg == ($past(s_axi_wdata[7:0]) & 8'h8f))
    else $error("blink control write not stored");
  a_wait_turns_off: assert property ( // R8
    wait_mode && cr1_reg[1] |=> !display_on)
    else $error("display stays on in wait mode");
  a_stop3_keeps_on: assert property ( // R9
    cr0_reg[7] && !wait_mode && !cr1_reg[0]
    ##1 cr0_reg[7] && !wait_mode && !cr1_reg[0] |-> display_on)
    else $error("display off in stop3 with disable clear");
  a_fp_gate_off: assert property ( // R15
    !display_on |-> frontplane_drive == '0)
    else $error("frontplane driven while display off");
  a_internal_supply: assert property ( // R5
    display_on && sup_cfg_reg[1:0] == 2'h0 |-> intermediate_supply_gen)
    else $error("intermediate supply not generated");
  a_bus_clock_ticks: assert property ( // R7
    clk_cfg_reg[7:6] == 2'h2 && clk_cfg_reg[5:0] == 6'h00
    && $stable(clk_cfg_reg) |=> tick_reg)
    else $error("bus clock source gives no display tick");
  a_pump_follows_en: assert property ( // R12
    pump_on |-> sup_cfg_reg[7] && on_reg)
    else $error("pump on without enable");

endmodule
`default_nettype wire

/* lsb_pkg.sv */
`default_nettype none
package lsb_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CLOCK_CFG = 8'h00;
  localparam logic [7:0] OFS_SUPPLY_CFG = 8'h04;
  localparam logic [7:0] OFS_CONTROL_ZERO = 8'h08;
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h0c;
  localparam logic [7:0] OFS_BLINK_CTRL = 8'h10;
  localparam logic [7:0] OFS_FP_ENABLE_LO = 8'h14;
  localparam logic [7:0] OFS_FP_ENABLE_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CLK_SOURCE_BIT = 7;
  localparam int CLK_DIVIDE_BY_SIXTEEN_BIT = 6;
  localparam int SUP_PUMP_EN_BIT = 7;
  localparam int SUP_PUMP_MULT_BIT = 6;
  localparam int SUP_PUMP_ADJ_LSB = 4;
  localparam int SUP_HIGH_DRIVE_BIT = 3;
  localparam int SUP_BYPASS_BIT = 2;
  localparam int CR0_MODULE_EN_BIT = 7;
  localparam int CR0_FRAME_SEL_LSB = 4;
  localparam int CR1_WAIT_DIS_BIT = 1;
  localparam int CR1_STOP3_DIS_BIT = 0;
  localparam int BLK_ENABLE_BIT = 7;
  localparam int BLK_ALL_BIT = 3;

  // ----------------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CLOCK_CFG_RST = 8'h00;
  localparam logic [7:0] SUPPLY_CFG_RST = 8'h00;
  localparam logic [7:0] CONTROL_ZERO_RST = 8'h00;
  localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] BLINK_CTRL_RST = 8'h00;
  localparam logic [1:0] SUPPLY_INTERNAL = 2'h0;
  localparam logic [1:0] DUTY_QUARTER = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------------
  localparam int PUMP_HALF_BASE = 6;
  localparam int PRESCALE_SIXTEEN = 16;
  localparam int BLINK_SHIFT = 4;

endpackage
`default_nettype wire

/* lsb_pump_if.sv */
`default_nettype none
interface lsb_pump_if;
  logic tick;
  logic enable;
  logic [1:0] adjust;
  logic pump_clk;
  modport ctrl (output tick, output enable, output adjust, input pump_clk);
  modport div (input tick, input enable, input adjust, output pump_clk);
endinterface
`default_nettype wire

/* lsb_pump_div.sv */
`default_nettype none
module lsb_pump_div (
  input wire logic aclk,
  input wire logic aresetn,
  lsb_pump_if.div pif
);

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic clk_reg;
  logic clk_next;
  logic [1:0] adj_reg;
  logic [1:0] adj_next;
  logic [5:0] half_m1;
  logic adj_change;

  // ----------------------------------------------------------------------
  // free-running half-period counter on display clock ticks
  // ----------------------------------------------------------------------
  // half period is 3 * 2^(adj+1) ticks, full period 6 * 2^(adj+1)
  assign half_m1 = 6'((lsb_pkg::PUMP_HALF_BASE << pif.adjust) - 1);
  assign adj_change = adj_reg != pif.adjust;

  // reload on any adjust change so no shortened half period escapes
  always_comb begin
    cnt_next = cnt_reg;
    clk_next = clk_reg;
    adj_next = pif.adjust;
    if (!pif.enable) begin
      cnt_next = half_m1;
      clk_next = 1'b0;
    end else if (adj_change) begin
      cnt_next = half_m1; // R16
    end else if (pif.tick) begin
      if (cnt_reg == 6'h00) begin
        cnt_next = half_m1; // R1
        clk_next = ~clk_reg;
      end else begin
        cnt_next = cnt_reg - 6'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 6'h00;
      clk_reg <= 1'b0;
      adj_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
      adj_reg <= adj_next;
    end
  end

  assign pif.pump_clk = clk_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [6:0] seen_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !pif.enable || adj_change || clk_next != clk_reg) begin
      seen_reg <= 7'h00;
    end else if (pif.tick) begin
      seen_reg <= seen_reg + 7'h01;
    end
  end

  a_half_period_len: assert property ( // R1
    @(posedge aclk) disable iff (!aresetn)
    (pif.enable && !adj_change && $past(pif.enable) && $changed(clk_reg)
     && $past(seen_reg) != 7'h00)
    |-> $past(seen_reg) == 7'({1'b0, half_m1}))
    else $error("pump clock half period length wrong");
  a_pump_off_low: assert property ( // R16
    @(posedge aclk) disable iff (!aresetn) !pif.enable |=> !clk_reg)
    else $error("pump clock runs while disabled");

endmodule
`default_nettype wire

/* lsb_glass_model.sv */
`default_nettype none
// ----------------------------------------------------------------------
// display glass: measures pump period, watches frontplane lines
// ----------------------------------------------------------------------
module lsb_glass_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pump_clk,
  input wire logic display_on,
  input wire logic [39:0] frontplane_drive,
  output logic [15:0] pump_period,
  output logic [7:0] pump_edges,
  output logic fp_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  logic [15:0] cnt;
  // period between rising pump edges, in bus clock cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
      cnt <= 16'h0000;
      pump_period <= 16'h0000;
      pump_edges <= 8'h00;
      fp_fault <= 1'b0;
    end else begin
      prev <= pump_clk;
      cnt <= cnt + 16'h0001;
      if (pump_clk && !prev) begin
        pump_period <= cnt + 16'h0001;
        cnt <= 16'h0000;
        pump_edges <= pump_edges + 8'h01;
      end
      // a dark glass must see no driven frontplane
      if (!display_on && frontplane_drive != 40'h0) fp_fault <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* tb_lcd_supply_blink_control.sv */
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_lcd_supply_blink_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp, duty;
  logic [2:0] ref_cnt = 0, fsel;
  logic wait_mode = 0, stop3_mode = 0, don, tick, pclk, pon, trip, hdrv;
  logic byp, igen, qd, ball, bsel, fault, s_all, s_sel;
  logic [39:0] fp;
  logic [15:0] period;
  logic [7:0] edges;
  logic [31:0] d;
  int error_cnt = 0, checked = 0;
  // ----------------------------------------------------------------------
  // clock, slow external reference (8 bus cycles)
  // ----------------------------------------------------------------------
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) ref_cnt <= ref_cnt + 3'h1;
  lsb_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_ref_clk(ref_cnt[2]), .wait_mode(wait_mode),
    .stop3_mode(stop3_mode), .display_on(don), .display_tick(tick),
    .pump_clk(pclk), .pump_on(pon), .pump_tripler(trip),
    .high_drive_select(hdrv), .buffer_bypass(byp),
    .intermediate_supply_gen(igen), .quarter_duty(qd), .duty_select(duty),
    .frame_clock_select(fsel), .blank_all(ball), .blank_selected(bsel),
    .frontplane_drive(fp));
  lsb_glass_model u_glass (.aclk(aclk), .aresetn(aresetn), .pump_clk(pclk),
    .display_on(don), .frontplane_drive(fp), .pump_period(period),
    .pump_edges(edges), .fp_fault(fault));
  // ----------------------------------------------------------------------
  // bus tasks: address and data offered together, answer awaited
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    bit aw_ok = 0, w_ok = 0;
    awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin aw_ok = 1; awvalid <= 0; end
      if (!w_ok && wready) begin w_ok = 1; wvalid <= 0; end
    end
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    araddr <= a; arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0; rready <= 1;
    do @(posedge aclk); while (!rvalid);
    v = rdata; r = rresp;
    rready <= 0;
  endtask
  // three fresh pump edges, so the last period follows a reload
  task automatic wait_pump();
    logic [7:0] e0;
    int n;
    e0 = edges;
    n = 0;
    while (8'(edges - e0) < 8'd3 && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 6000) error_cnt++;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog well beyond the longest pump measurement
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    close_out();
  end
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), d, resp);
      `CHK(d, 32'h0)
    end
    rd(8'h20, d, resp);
    `CHK({resp, d}, {lsb_pkg::RESP_SLVERR, 32'h0})
    wr(8'h1c, 32'hff, resp);
    `CHK(resp, lsb_pkg::RESP_SLVERR)
    wr(lsb_pkg::OFS_CLOCK_CFG, 32'h80, resp);
    wr(lsb_pkg::OFS_SUPPLY_CFG, 32'h84, resp);
    `CHK({trip, hdrv, byp}, 3'b001)
    wr(lsb_pkg::OFS_SUPPLY_CFG, 32'hc8, resp);
    `CHK({trip, hdrv, byp}, 3'b110)
    rd(lsb_pkg::OFS_SUPPLY_CFG, d, resp);
    `CHK(d, 32'hc8)
    wr(lsb_pkg::OFS_CONTROL_ZERO, 32'hb3, resp);
    repeat (2) @(posedge aclk);
    `CHK({don, qd, duty, fsel}, 7'b1111011)
    `CHK({pon, igen}, 2'b11)
    `CHK(tick, 1'b1)
    wr(lsb_pkg::OFS_FP_ENABLE_LO, 32'ha5a5a5a5, resp);
    wr(lsb_pkg::OFS_FP_ENABLE_HI, 32'hff3c, resp);
    `CHK(fp, 40'h3ca5a5a5a5)
    rd(lsb_pkg::OFS_FP_ENABLE_HI, d, resp);
    `CHK(d, 32'h3c)
    for (int p = 0; p < 4; p++) begin
      wr(lsb_pkg::OFS_SUPPLY_CFG, 32'h80 | (p << 4), resp);
      wait_pump();
      `CHK(period, 16'(12 << p))
    end
    wr(lsb_pkg::OFS_CLOCK_CFG, 32'h81, resp);
    wait_pump();
    `CHK(period, 16'd192)
    wr(lsb_pkg::OFS_CLOCK_CFG, 32'hc0, resp);
    wait_pump();
    `CHK(period, 16'd1536)
    wr(lsb_pkg::OFS_CLOCK_CFG, 32'h00, resp);
    wait_pump();
    `CHK(period, 16'd768)
    wr(lsb_pkg::OFS_CLOCK_CFG, 32'h80, resp);
    wr(lsb_pkg::OFS_CONTROL_ONE, 32'h02, resp);
    wait_mode <= 1;
    repeat (3) @(posedge aclk);
    `CHK({don, fp}, 41'h0)
    wait_mode <= 0;
    stop3_mode <= 1;
    repeat (3) @(posedge aclk);
    `CHK(don, 1'b1)
    wr(lsb_pkg::OFS_CONTROL_ONE, 32'h01, resp);
    repeat (3) @(posedge aclk);
    `CHK(don, 1'b0)
    stop3_mode <= 0;
    for (int m = 0; m < 2; m++) begin
      wr(lsb_pkg::OFS_BLINK_CTRL, 32'h00, resp);
      wr(lsb_pkg::OFS_BLINK_CTRL, m ? 32'h88 : 32'h80, resp);
      s_all = 0;
      s_sel = 0;
      repeat (80) begin
        @(posedge aclk);
        s_all |= ball;
        s_sel |= bsel;
      end
      `CHK({s_all, s_sel}, m ? 2'b10 : 2'b01)
    end
    rd(lsb_pkg::OFS_BLINK_CTRL, d, resp);
    `CHK(d, 32'h88)
    `CHK(fault, 1'b0)
    close_out();
  end
endmodule
`default_nettype wire
